//--- rtl/aps_pkg.sv
package aps_pkg;
  typedef enum logic [1:0] {
    APS_ST_INIT,
    APS_ST_MAIN,
    APS_ST_RELEASING,
    APS_ST_RESERVE
  } aps_state_type;
endpackage

//--- rtl/aps_regs.svh
`ifndef APS_REGS_SVH
`define APS_REGS_SVH

// ==========================================
// Register map
`define APS_CTRL_OFS 12'h000
`define APS_STATUS_OFS 12'h004
`define APS_COUNT_OFS 12'h008

// ==========================================
// Fields
`define APS_CTRL_REQ_BIT 0
`define APS_CTRL_INHIBIT_BIT 1
`define APS_CTRL_RESET 32'h0000_0000

// ==========================================
// Detection figures
`define APS_WINDOW_CLOCKS 512
`define APS_MIN_PULSES 120
`define APS_AIS_RUN 2048

// ==========================================
// Timing
`define APS_CLK_PERIOD_NS 8
`define APS_DEBOUNCE_NS 1000
`define APS_DEBOUNCE_CYCLES ((`APS_DEBOUNCE_NS + `APS_CLK_PERIOD_NS - 1) / `APS_CLK_PERIOD_NS)

`endif

//--- rtl/aps_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"

module aps_top #(
  parameter int DEBOUNCE_CYCLES = `APS_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Recovered marks
  input wire logic mark_pos,
  input wire logic mark_neg,
  input wire logic mark_qualified,
  output logic data_pos_out,
  output logic data_neg_out,
  // Front panel and straps
  input wire logic ais_disable_jumper,
  input wire logic inhibit_switch,
  input wire logic change_request_button,
  input wire logic ext_change_req_n,
  input wire logic power_fail,
  input wire logic relay_latched_main,
  // Handshake link
  input wire logic partner_sense_n,
  input wire logic partner_power,
  input wire logic partner_status_in,
  input wire logic partner_release_in,
  input wire logic partner_alarm_in,
  input wire logic partner_inhibit_in,
  output logic status_out,
  output logic release_out,
  output logic alarm_to_partner,
  output logic inhibit_to_partner,
  // Relay and indicators
  output logic main_select,
  output logic relay_reset,
  output logic loss_led,
  output logic ais_led,
  output logic in_service_led,
  output logic standby_led,
  output logic general_alarm_n
);

  // Debounce counter is 16 bits wide
  if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 65535) begin : g_bad_debounce
    $error("DEBOUNCE_CYCLES out of range");
  end

  localparam int NIN = 9;
  localparam logic [15:0] DB_MAX = 16'(DEBOUNCE_CYCLES - 1);
  // Idle level of each line, so reset release never looks like an edge
  localparam logic [NIN-1:0] IDLE_IN = 9'h03C;
  localparam logic [16:0] SETTLE_MAX = 17'(DEBOUNCE_CYCLES + 3);

  // ==========================================
  // Input synchronisers and debounce
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] clean_q;
  logic [15:0] db_cnt_q [NIN];

  assign raw_in = {partner_inhibit_in, partner_alarm_in, partner_release_in,
                   partner_status_in, partner_power, partner_sense_n,
                   ext_change_req_n, change_request_button, inhibit_switch};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= IDLE_IN;
      sync2_q <= IDLE_IN;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // Level must hold steady for the whole debounce time before it is accepted
  always_ff @(posedge clk) begin
    if (rst) begin
      clean_q <= IDLE_IN;
      for (int i = 0; i < NIN; i++) begin
        db_cnt_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (sync2_q[i] == clean_q[i]) begin
          db_cnt_q[i] <= 16'h0000;
        end else if (db_cnt_q[i] == DB_MAX) begin
          db_cnt_q[i] <= 16'h0000;
          clean_q[i] <= sync2_q[i];
        end else begin
          db_cnt_q[i] <= db_cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  logic inhibit_own;
  logic button;
  logic ext_req;
  logic paired;
  logic partner_up;
  logic partner_claim;
  logic partner_releasing;
  logic partner_faulty;
  logic partner_inhibit;
  logic ctrl_req_q;
  logic ctrl_inhibit_q;

  assign inhibit_own = clean_q[0] | ctrl_inhibit_q;
  assign button = clean_q[1];
  assign ext_req = ~clean_q[2];
  assign paired = ~clean_q[3];
  assign partner_up = clean_q[4];
  assign partner_claim = ~clean_q[5];
  assign partner_releasing = clean_q[6];
  assign partner_faulty = clean_q[7];
  assign partner_inhibit = clean_q[8];

  // ==========================================
  // Data path
  // Plain reclock; outputs never forced to ones on loss
  always_ff @(posedge clk) begin
    if (rst) begin
      data_pos_out <= 1'b0;
      data_neg_out <= 1'b0;
    end else begin
      data_pos_out <= mark_pos;
      data_neg_out <= mark_neg;
    end
  end

  logic pulse;
  assign pulse = (mark_pos | mark_neg) & mark_qualified;

  // ==========================================
  // Loss and AIS detection
  logic [9:0] win_cnt_q;
  logic [9:0] pulse_cnt_q;
  logic [9:0] last_count_q;
  logic [11:0] run_q;
  logic loss_q;
  logic ais_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      win_cnt_q <= 10'h000;
      pulse_cnt_q <= 10'h000;
      last_count_q <= 10'h000;
      loss_q <= 1'b0;
    end else if (win_cnt_q == 10'(`APS_WINDOW_CLOCKS - 1)) begin
      win_cnt_q <= 10'h000;
      pulse_cnt_q <= 10'h000;
      last_count_q <= pulse_cnt_q + {9'h000, pulse};
      loss_q <= (pulse_cnt_q + {9'h000, pulse}) < 10'(`APS_MIN_PULSES);
    end else begin
      win_cnt_q <= win_cnt_q + 10'h001;
      pulse_cnt_q <= pulse_cnt_q + {9'h000, pulse};
    end
  end

  // Run counter saturates so a long AIS never wraps back to clear
  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 12'h000;
      ais_q <= 1'b0;
    end else if (!pulse) begin
      run_q <= 12'h000;
      ais_q <= 1'b0;
    end else if (run_q == 12'(`APS_AIS_RUN)) begin
      ais_q <= 1'b1;
    end else begin
      run_q <= run_q + 12'h001;
    end
  end

  logic ais_effective;
  logic alarm;
  logic fault;
  assign ais_effective = ais_q & ~ais_disable_jumper;
  assign alarm = loss_q | ais_effective;
  assign fault = alarm | power_fail;

  // ==========================================
  // Indicators and alarm contact
  always_ff @(posedge clk) begin
    if (rst) begin
      loss_led <= 1'b0;
      ais_led <= 1'b0;
      general_alarm_n <= 1'b1;
      alarm_to_partner <= 1'b0;
      inhibit_to_partner <= 1'b0;
    end else begin
      loss_led <= loss_q;
      ais_led <= ais_q;
      general_alarm_n <= ~alarm;
      alarm_to_partner <= fault;
      inhibit_to_partner <= inhibit_own;
    end
  end

  // ==========================================
  // Main / reserve arbitration
  aps_pkg::aps_state_type state_q;
  logic [16:0] settle_q;
  logic claim_prev_q;
  logic claim_rise;
  logic inhibit_any;
  logic manual_req;
  logic can_release;

  assign inhibit_any = inhibit_own | partner_inhibit;
  assign manual_req = (button & ~alarm)
                    | (ext_req & ~inhibit_own)
                    | (ctrl_req_q & ~alarm);
  assign can_release = fault & ~inhibit_any & ~partner_faulty & partner_up;
  // In MAIN only a fresh claim forces us off; a claim still fading after takeover must not
  assign claim_rise = partner_claim & ~claim_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      claim_prev_q <= 1'b0;
    end else begin
      claim_prev_q <= partner_claim;
    end
  end

  // Arbitration waits until every debounced line has settled after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 17'h00000;
    end else if (settle_q != SETTLE_MAX) begin
      settle_q <= settle_q + 17'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= aps_pkg::APS_ST_INIT;
    end else if (settle_q != SETTLE_MAX) begin
      state_q <= aps_pkg::APS_ST_INIT;
    end else if (!paired) begin
      state_q <= aps_pkg::APS_ST_MAIN; // stand-alone always drives the path
    end else begin
      case (state_q)
        aps_pkg::APS_ST_INIT: begin
          if (partner_claim || !relay_latched_main) begin
            state_q <= aps_pkg::APS_ST_RESERVE;
          end else begin
            state_q <= aps_pkg::APS_ST_MAIN;
          end
        end
        aps_pkg::APS_ST_MAIN: begin
          if (claim_rise && partner_up) begin
            state_q <= aps_pkg::APS_ST_RESERVE;
          end else if (can_release) begin
            state_q <= aps_pkg::APS_ST_RELEASING;
          end
        end
        aps_pkg::APS_ST_RELEASING: begin
          if (partner_claim) begin
            state_q <= aps_pkg::APS_ST_RESERVE;
          end else if (!can_release) begin
            state_q <= aps_pkg::APS_ST_MAIN;
          end
        end
        aps_pkg::APS_ST_RESERVE: begin
          if (!partner_up) begin
            state_q <= aps_pkg::APS_ST_MAIN;
          end else if (partner_releasing && !fault && !inhibit_any) begin
            state_q <= aps_pkg::APS_ST_MAIN;
          end else if (manual_req) begin
            state_q <= aps_pkg::APS_ST_MAIN;
          end
          // Recovery alone never brings us back
        end
        default: begin
          state_q <= aps_pkg::APS_ST_INIT;
        end
      endcase
    end
  end

  logic is_main;
  assign is_main = (state_q == aps_pkg::APS_ST_MAIN) || (state_q == aps_pkg::APS_ST_RELEASING);

  // ==========================================
  // Link and relay outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      status_out <= 1'b1;
      release_out <= 1'b0;
      main_select <= 1'b0;
      relay_reset <= 1'b0;
      in_service_led <= 1'b0;
      standby_led <= 1'b0;
    end else begin
      status_out <= ~(is_main & paired);
      release_out <= (state_q == aps_pkg::APS_ST_RELEASING);
      main_select <= is_main;
      relay_reset <= paired & partner_claim & ~is_main;
      in_service_led <= is_main;
      standby_led <= (state_q == aps_pkg::APS_ST_RESERVE);
    end
  end

  // ==========================================
  // APB slave, one wait state per access
  logic access;
  logic mapped;
  assign access = psel & penable & ~pready;
  assign mapped = (paddr == `APS_CTRL_OFS) || (paddr == `APS_STATUS_OFS)
               || (paddr == `APS_COUNT_OFS);

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
      if (access && !pwrite) begin
        case (paddr)
          `APS_CTRL_OFS: prdata <= {30'h0, ctrl_inhibit_q, ctrl_req_q};
          `APS_STATUS_OFS: prdata <= {20'h0, paired, partner_up, partner_claim,
                                      partner_releasing, 2'(state_q), is_main,
                                      ais_disable_jumper, general_alarm_n, fault,
                                      ais_q, loss_q};
          `APS_COUNT_OFS: prdata <= {4'h0, run_q, 6'h00, last_count_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Software request holds until taken or refused by alarm
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_req_q <= 1'b0;
      ctrl_inhibit_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == `APS_CTRL_OFS) begin
      // Write lands at the edge where the master sees pready
      ctrl_req_q <= pwdata[`APS_CTRL_REQ_BIT];
      ctrl_inhibit_q <= pwdata[`APS_CTRL_INHIBIT_BIT];
    end else if (is_main || alarm) begin
      ctrl_req_q <= 1'b0;
    end
  end

endmodule // aps_top

`default_nettype wire

//--- verif/alarm_and_protection_switch_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module alarm_and_protection_switch_logic_tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, mark_pos, mark_neg, mark_qualified;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_q;
  logic data_pos_out, ais_disable_jumper, inhibit_switch, partner_sense_n, partner_power;
  logic partner_status_in, partner_release_in, partner_alarm_in, partner_inhibit_in, powered;
  logic status_out, release_out, loss_led, ais_led, in_service_led, general_alarm_n;
  logic ext_req_n, button, pfail, failing;
  logic [1:0] mode;
  logic [33:0] e_q;
  logic [33:0] exp_q[$];
  int fail_count, compares;
  aps_top #(.DEBOUNCE_CYCLES(2)) uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .mark_pos, .mark_neg, .mark_qualified, .data_pos_out,
    .data_neg_out(), .ais_disable_jumper, .inhibit_switch, .change_request_button(button),
    .ext_change_req_n(ext_req_n), .power_fail(pfail), .relay_latched_main(1'b1), .partner_sense_n,
    .partner_power, .partner_status_in, .partner_release_in, .partner_alarm_in,
    .partner_inhibit_in, .status_out, .release_out, .alarm_to_partner(), .inhibit_to_partner(),
    .main_select(), .relay_reset(), .loss_led, .ais_led, .in_service_led, .standby_led(),
    .general_alarm_n);
  aps_peer_model peer (.clk, .rst, .powered, .failing, .status_out, .release_out, .partner_status_in,
    .partner_release_in, .partner_alarm_in, .partner_inhibit_in, .partner_power);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Queue entry: read flag, error flag, data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    lfsr_q <= rst ? 32'hA54C4151 : nxt(lfsr_q);
    mark_pos <= (mode == 2'h2) | ((mode == 2'h1) & lfsr_q[0]);
    mark_neg <= (mode == 2'h1) & ~lfsr_q[0] & lfsr_q[1];
  end
  always @(posedge clk) if (pready === 1'b1) begin
    e_q = exp_q.pop_front();
    chk("pslverr", {31'h0, pslverr}, {31'h0, e_q[32]});
    if (e_q[33]) chk("prdata", prdata, e_q[31:0]);
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rst, mode, powered, pfail, failing, button, ext_req_n} = {1'b1, 2'h1, 4'h8, 1'b1};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mark_qualified, ais_disable_jumper, inhibit_switch, partner_sense_n} = 4'h8;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, {2'h2, 32'h0});
    apb(1'b0, 12'h00C, 32'h0, {2'h3, 32'h0});
    apb(1'b1, 12'h000, 32'h2, {2'h0, 32'h0});
    apb(1'b0, 12'h000, 32'h0, {2'h2, 32'h2});
    apb(1'b1, 12'h000, 32'h0, {2'h0, 32'h0});
    repeat (40) @(negedge clk);
    chk("in_service", in_service_led, 1'b1);
    apb(1'b0, 12'h004, 32'h0, {2'h2, 32'h0000_0C68});
    @(posedge clk);
    mark_qualified <= 1'b0;
    inhibit_switch <= 1'b1;
    for (int i = 0; i < 1100 && loss_led !== 1'b1; i++) @(negedge clk);
    chk("loss", loss_led, 1'b1);
    chk("alarm", general_alarm_n, 1'b0);
    repeat (30) @(negedge clk);
    chk("release", release_out, 1'b0);
    @(posedge clk);
    inhibit_switch <= 1'b0;
    for (int i = 0; i < 80 && in_service_led !== 1'b0; i++) @(negedge clk);
    chk("in_service", in_service_led, 1'b0);
    @(posedge clk);
    button <= 1'b1;
    repeat (30) @(negedge clk);
    chk("in_service", in_service_led, 1'b0);
    @(posedge clk);
    button <= 1'b0;
    mark_qualified <= 1'b1;
    repeat (1100) @(negedge clk);
    chk("loss", loss_led, 1'b0);
    chk("in_service", in_service_led, 1'b0);
    @(posedge clk);
    failing <= 1'b1;
    for (int i = 0; i < 80 && in_service_led !== 1'b1; i++) @(negedge clk);
    chk("in_service", in_service_led, 1'b1);
    repeat (5) @(negedge clk);
    chk("peer_yield", partner_status_in, 1'b1);
    @(posedge clk);
    failing <= 1'b0;
    pfail <= 1'b1;
    for (int i = 0; i < 80 && in_service_led !== 1'b0; i++) @(negedge clk);
    chk("in_service", in_service_led, 1'b0);
    @(posedge clk);
    pfail <= 1'b0;
    inhibit_switch <= 1'b1;
    ext_req_n <= 1'b0;
    repeat (30) @(negedge clk);
    chk("in_service", in_service_led, 1'b0);
    @(posedge clk);
    inhibit_switch <= 1'b0;
    for (int i = 0; i < 80 && in_service_led !== 1'b1; i++) @(negedge clk);
    chk("in_service", in_service_led, 1'b1);
    repeat (5) @(negedge clk);
    chk("peer_yield", partner_status_in, 1'b1);
    @(posedge clk);
    ext_req_n <= 1'b1;
    pfail <= 1'b1;
    for (int i = 0; i < 80 && in_service_led !== 1'b0; i++) @(negedge clk);
    chk("in_service", in_service_led, 1'b0);
    @(posedge clk);
    pfail <= 1'b0;
    powered <= 1'b0;
    for (int i = 0; i < 80 && in_service_led !== 1'b1; i++) @(negedge clk);
    chk("in_service", in_service_led, 1'b1);
    @(posedge clk);
    partner_sense_n <= 1'b1;
    repeat (20) @(negedge clk);
    chk("status", status_out, 1'b1);
    @(posedge clk);
    ais_disable_jumper <= 1'b1;
    mode <= 2'h2;
    for (int i = 0; i < 2300 && ais_led !== 1'b1; i++) @(negedge clk);
    chk("ais_led", ais_led, 1'b1);
    repeat (3) @(negedge clk);
    chk("alarm", general_alarm_n, 1'b1);
    chk("data", data_pos_out, 1'b1);
    @(posedge clk);
    ais_disable_jumper <= 1'b0;
    repeat (4) @(negedge clk);
    chk("alarm", general_alarm_n, 1'b0);
    @(posedge clk);
    ais_disable_jumper <= 1'b1;
    mode <= 2'h0;
    for (int i = 0; i < 1100 && loss_led !== 1'b1; i++) @(negedge clk);
    chk("alarm", general_alarm_n, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    mode <= 2'h1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    chk("alarm", general_alarm_n, 1'b1);
    report_and_stop();
  end
endmodule // alarm_and_protection_switch_logic_tb_top
`default_nettype wire

//--- verif/aps_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module aps_chk_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic mark_pos,
  input wire logic data_pos_out,
  input wire logic ais_disable_jumper,
  input wire logic partner_sense_n,
  input wire logic status_out,
  input wire logic release_out,
  input wire logic main_select,
  input wire logic relay_reset,
  input wire logic loss_led,
  input wire logic ais_led,
  input wire logic in_service_led,
  input wire logic standby_led,
  input wire logic general_alarm_n
);
  logic [9:0] cyc_q;
  // Saturates so it never wraps back
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_q <= 10'h000;
    end else if (cyc_q != 10'h3FF) begin
      cyc_q <= cyc_q + 10'h001;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  AST_PASS_DATA:
    assert property (!$past(rst) |-> data_pos_out == $past(mark_pos)) else $error("data altered");
  AST_LOSS_ALARM:
    assert property (loss_led |-> !general_alarm_n) else $error("loss without alarm");
  AST_AIS_ALARM:
    assert property ((ais_led && !ais_disable_jumper)[*3] |-> !general_alarm_n) else $error("ais quiet");
  AST_AIS_MUTED:
    assert property ((ais_led && ais_disable_jumper && !loss_led)[*3] |-> general_alarm_n)
      else $error("muted ais alarmed");
  AST_IN_SERVICE:
    assert property (in_service_led |-> main_select && !standby_led) else $error("service led");
  AST_UNPAIRED:
    assert property (partner_sense_n[*8] ##1 partner_sense_n[*4] |-> status_out && !release_out)
      else $error("handshake while unpaired");
  AST_RELAY:
    assert property (relay_reset |-> !main_select) else $error("relay set and reset");
  AST_FIRST_WINDOW:
    assert property (cyc_q < 10'h1F4 |-> !loss_led) else $error("early loss");
  COV_LOSS: cover property ($rose(loss_led));
  COV_AIS: cover property ($rose(ais_led));
  COV_RELEASE: cover property ($rose(release_out));
endmodule // aps_chk_sva
bind aps_top aps_chk_sva u_sva (.clk, .rst, .mark_pos, .data_pos_out, .ais_disable_jumper,
  .partner_sense_n, .status_out, .release_out, .main_select, .relay_reset, .loss_led, .ais_led,
  .in_service_led, .standby_led, .general_alarm_n);
`default_nettype wire

//--- verif/aps_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Companion module
module aps_peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic powered,
  input wire logic failing,
  // Link
  input wire logic status_out,
  input wire logic release_out,
  output logic partner_status_in,
  output logic partner_release_in,
  output logic partner_alarm_in,
  output logic partner_inhibit_in,
  output logic partner_power
);
  logic main_q;
  logic seen_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q <= 1'b1;
    end else begin
      seen_q <= status_out;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || !powered) begin
      main_q <= 1'b0;
    end else if (!main_q && release_out && !failing) begin
      main_q <= 1'b1;
    end else if (main_q && !status_out && seen_q) begin
      main_q <= 1'b0;
    end
  end
  // Unpowered end lets the line float high
  assign partner_status_in = !(main_q && powered);
  assign partner_release_in = main_q && failing && powered;
  assign partner_alarm_in = !powered || failing;
  assign partner_inhibit_in = 1'b0;
  assign partner_power = powered;
endmodule // aps_peer_model
`default_nettype wire
